//--- design/power_monitor_pkg.sv
// Constants shared by the power monitor result and limit logic.
// Assumes a 16-bit register port fed by a serial slave outside this block.
// Summary of operation
// - Smallest gain: shunt result is 12-bit signed, D15..D12 all sign copies.
// - Bus range 10/11: 14-bit result in D15..D2, done in D1, overflow D0.
// - Range 01: 13 bits in D15..D3; range 00: 12 bits in D14..D3.
// - Bus result step is 4 mV for every range; only valid bits change.
// - Done flag works in triggered modes; low while converting, high after.
// - Done flag clears on configuration write and on power result read.
// - Overflow flag sets when current or power result is out of range.
// - Calibration at 05h is read/write, scale in 15..1, bit 0 reads zero.
// - Current uses shunt times calibration with 4096 internal resolution.
// - Conversion settings 3 and above mean 15-bit resolution, span 32768.
// - Current result at 04h is read-only 16-bit two's complement.
// - Power result at 03h is read-only, meaningful only after calibration.
// - Power step is current step times bus step times 5000; 60 V doubles.
// - Bus result at 02h is read-only, formatted by the bus range select.
// - Each reading is compared with its limits once per conversion.
// - Limit breach sets its warning; alert pin with alert enable, or always with the force bit.
// - Shunt limit step is 2.56 mV.
// - Bus limits at 07h: unsigned upper byte maximum, lower minimum, 256 mV.
// - Warnings at 08h bits 3..0 read one when set; write one clears.
// - With alert enable, any set warning pulls the alert pin low.
// - Bus range select 00 is 16 V, 01 is 32 V, 10 or 11 is 60 V.
package power_monitor_pkg;
  localparam logic [3:0] ADDR_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_SHUNT = 4'h1;
  localparam logic [3:0] ADDR_BUS = 4'h2;
  localparam logic [3:0] ADDR_POWER = 4'h3;
  localparam logic [3:0] ADDR_CURRENT = 4'h4;
  localparam logic [3:0] ADDR_CAL = 4'h5;
  localparam logic [3:0] ADDR_SHUNT_LIM = 4'h6;
  localparam logic [3:0] ADDR_BUS_LIM = 4'h7;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_AUX = 4'h9;
  // Field positions
  localparam int WARN_SHUNT_HI = 3;
  localparam int WARN_SHUNT_LO = 2;
  localparam int WARN_BUS_HI = 1;
  localparam int WARN_BUS_LO = 0;
  localparam int AUX_FORCE = 8;
  localparam int AUX_ALERT_EN = 7;
  // Reset values
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] RESET_BUS_LIM = 16'hFF00;
  localparam logic [15:0] RESET_SHUNT_LIM = 16'h7F80;
  // Arithmetic constants
  localparam int MATH_SHIFT = 12;
  localparam int SHUNT_CMP_SHIFT = 8;
  localparam int BUS_CMP_SHIFT = 6;
  localparam logic [3:0] FULL_RES_SETTING = 4'h3;
  localparam logic [29:0] POWER_DIVISOR = 30'h00001388;
  typedef enum logic [1:0] {
    IDLE = 2'b00,
    CALC = 2'b01,
    CHECK = 2'b11
  } state_t;
endpackage

//--- design/power_monitor_result_registers.sv
// Result, calibration, limit and warning registers of the power monitor.
// Assumes an outside serial slave giving single-cycle read/write strobes
// and an ADC giving one sample pulse per completed conversion.
`timescale 1ns/10ps
`default_nettype none
module power_monitor_result_registers
  import power_monitor_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdData,
  input wire logic sampleValid,
  input wire logic [15:0] sampleShunt,
  input wire logic [13:0] sampleBus,
  input wire logic [1:0] busRangeSelect,
  input wire logic [1:0] shuntGainSelect,
  input wire logic [3:0] shuntConversionSetting,
  input wire logic triggeredMode,
  input wire logic alertPinIn,
  output logic alertPinOut,
  output logic alertPinOe
);

  typedef struct packed {
    state_t state;
    logic [15:0] shunt;
    logic [13:0] busCode;
    logic [15:0] current;
    logic [15:0] power;
    logic [14:0] calScaleBits;
    logic [15:0] shuntLimits;
    logic [15:0] busLimits;
    logic [3:0] warn;
    logic thresholdAlertEnable;
    logic forceAlert;
    logic convDone;
    logic mathOverrange;
    logic alertDrive;
    logic [15:0] rdData;
  } regs_t;

  regs_t s;
  regs_t next_s;

  // Sign-extend the shunt sample from the top bit of the gain range
  function automatic logic [15:0] fmtShunt(input logic [15:0] raw,
                                            input logic [1:0] gain);
    logic [15:0] res;
    res = raw;
    case (gain)
      2'b00: res = {{4{raw[11]}}, raw[11:0]};
      2'b01: res = {{3{raw[12]}}, raw[12:0]};
      2'b10: res = {{2{raw[13]}}, raw[13:0]};
      default: res = raw;
    endcase
    return res;
  endfunction

  // Place the 4 mV bus code by range, flags in the two low bits
  function automatic logic [15:0] fmtBus(input logic [13:0] code,
                                          input logic [1:0] range,
                                          input logic done,
                                          input logic ovf);
    logic [15:0] res;
    res = 16'h0000;
    case (range)
      2'b00: res = {1'b0, code[11:0], 1'b0, done, ovf};
      2'b01: res = {code[12:0], 1'b0, done, ovf};
      default: res = {code, done, ovf};
    endcase
    return res;
  endfunction

  // Resolution shift: settings from 3 up count as full 15-bit span
  function automatic logic [1:0] resShift(input logic [3:0] setting);
    logic [1:0] sh;
    sh = 2'h0;
    if (setting >= FULL_RES_SETTING) begin
      sh = 2'h0;
    end else begin
      sh = 2'(FULL_RES_SETTING[1:0] - setting[1:0]);
    end
    return sh;
  endfunction

  // One decode for the config write, power read and status write strobes
  function automatic logic hitAddr(input logic strobe,
                                   input logic [3:0] addr,
                                   input logic [3:0] target);
    return strobe && (addr == target);
  endfunction

  // Arithmetic and limit checks
  logic signed [32:0] product;
  logic signed [35:0] curWide;
  logic [15:0] curMag;
  logic [29:0] powWide;
  logic [29:0] powQuot;
  logic curOvf;
  logic powOvf;
  logic [3:0] warnSet;
  logic [3:0] warnClr;
  logic [7:0] busScaled;
  logic signed [7:0] shuntScaled;
  logic isWrite;
  logic powerRead;
  logic configWrite;

  // Current from shunt times calibration, scaled by the internal 4096
  always_comb begin
    product = $signed(s.shunt) * $signed({1'b0, s.calScaleBits, 1'b0});
    curWide = ($signed({{3{product[32]}}, product})
               <<< resShift(shuntConversionSetting)) >>> MATH_SHIFT;
    curOvf = ~((&curWide[35:15]) | ~(|curWide[35:15]));
    curMag = curWide[15] ? 16'(-curWide[15:0]) : curWide[15:0];
  end

  // Power in units of current step times bus step times 5000
  always_comb begin
    powWide = 30'(curMag * s.busCode);
    powQuot = powWide / POWER_DIVISOR;
    if (busRangeSelect[1]) begin
      powQuot = powQuot >> 1;
    end
    powOvf = |powQuot[29:16];
  end

  // Readings aligned to the threshold steps
  assign shuntScaled = $signed(s.shunt[15:SHUNT_CMP_SHIFT]);
  assign busScaled = s.busCode[13:BUS_CMP_SHIFT];

  // Compare once, in the check state of each conversion
  always_comb begin
    warnSet = 4'h0;
    if (s.state == CHECK) begin
      warnSet[WARN_SHUNT_HI] = shuntScaled > $signed(s.shuntLimits[15:8]);
      warnSet[WARN_SHUNT_LO] = shuntScaled < $signed(s.shuntLimits[7:0]);
      warnSet[WARN_BUS_HI] = busScaled > s.busLimits[15:8];
      warnSet[WARN_BUS_LO] = busScaled < s.busLimits[7:0];
    end
  end

  // Host strobes
  assign isWrite = regWrite;
  assign configWrite = hitAddr(isWrite, regAddr, ADDR_CONFIG);
  assign powerRead = hitAddr(regRead, regAddr, ADDR_POWER);
  assign warnClr = hitAddr(isWrite, regAddr, ADDR_STATUS) ? regWrData[3:0] : 4'h0;

  // Next state of the whole block
  always_comb begin
    next_s = s;
    next_s.rdData = s.rdData;

    // Conversion sequence
    case (s.state)
      IDLE: begin
        if (sampleValid) begin
          next_s.shunt = fmtShunt(sampleShunt, shuntGainSelect);
          next_s.busCode = sampleBus;
          next_s.convDone = 1'b0;
          next_s.state = CALC;
        end
      end
      CALC: begin
        next_s.current = curWide[15:0];
        next_s.power = powQuot[15:0];
        next_s.mathOverrange = curOvf | powOvf;
        next_s.state = CHECK;
      end
      CHECK: begin
        next_s.state = IDLE;
      end
      default: begin
        next_s.state = IDLE;
      end
    endcase

    // Done flag: host clear first, completion set wins
    if (configWrite || powerRead) begin
      next_s.convDone = 1'b0;
    end
    if (s.state == CHECK && triggeredMode) begin
      next_s.convDone = 1'b1;
    end

    // Register writes
    if (isWrite) begin
      case (regAddr)
        ADDR_CAL: next_s.calScaleBits = regWrData[15:1];
        ADDR_SHUNT_LIM: next_s.shuntLimits = regWrData;
        ADDR_BUS_LIM: next_s.busLimits = regWrData;
        ADDR_AUX: begin
          next_s.thresholdAlertEnable = regWrData[AUX_ALERT_EN];
          next_s.forceAlert = regWrData[AUX_FORCE];
        end
        default: begin
          next_s.rdData = s.rdData;
        end
      endcase
    end

    // Warnings: write one clears, a new breach in the same cycle wins
    next_s.warn = (s.warn & ~warnClr) | warnSet;

    // Alert pin pulled low while enabled warnings stand or forced
    next_s.alertDrive = (s.thresholdAlertEnable && (|s.warn)) || s.forceAlert;

    // Read data, captured one cycle after the strobe
    if (regRead) begin
      case (regAddr)
        ADDR_SHUNT: next_s.rdData = s.shunt;
        ADDR_BUS: next_s.rdData = fmtBus(s.busCode, busRangeSelect,
                                         s.convDone, s.mathOverrange);
        ADDR_POWER: next_s.rdData = s.power;
        ADDR_CURRENT: next_s.rdData = s.current;
        ADDR_CAL: next_s.rdData = {s.calScaleBits, 1'b0};
        ADDR_SHUNT_LIM: next_s.rdData = s.shuntLimits;
        ADDR_BUS_LIM: next_s.rdData = s.busLimits;
        ADDR_STATUS: next_s.rdData = {12'h000, s.warn};
        ADDR_AUX: next_s.rdData = {7'h00, s.forceAlert,
                                   s.thresholdAlertEnable, 7'h00};
        default: next_s.rdData = 16'h0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s.state <= IDLE;
      s.shunt <= RESET_WORD;
      s.busCode <= 14'h0000;
      s.current <= RESET_WORD;
      s.power <= RESET_WORD;
      s.calScaleBits <= 15'h0000;
      s.shuntLimits <= RESET_SHUNT_LIM;
      s.busLimits <= RESET_BUS_LIM;
      s.warn <= 4'h0;
      s.thresholdAlertEnable <= 1'b0;
      s.forceAlert <= 1'b0;
      s.convDone <= 1'b0;
      s.mathOverrange <= 1'b0;
      s.alertDrive <= 1'b0;
      s.rdData <= RESET_WORD;
    end else begin
      s <= next_s;
    end
  end

  // Outputs; the alert pin is open drain, driven only low
  assign regRdData = s.rdData;
  assign alertPinOut = 1'b0;
  assign alertPinOe = s.alertDrive;

endmodule
`default_nettype wire

//--- sim/power_monitor_host.sv
// Host side model: single-cycle register strobes on the word port.
// Assumes the bench calls its tasks; released write data is scrambled.
`timescale 1ns/10ps
`default_nettype none
module power_monitor_host (
  input wire logic clock,
  input wire logic [15:0] regRdData,
  output logic [3:0] regAddr,
  output logic [15:0] regWrData,
  output logic regWrite,
  output logic regRead
);
  // Idle strobes from time zero
  initial begin
    regAddr = 4'h0;
    regWrData = 16'h0000;
    regWrite = 1'b0;
    regRead = 1'b0;
  end
  // Write strobe for one cycle, data inverted once released
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(negedge clock);
    regAddr = a;
    regWrData = d;
    regWrite = 1'b1;
    @(negedge clock);
    regWrite = 1'b0;
    regWrData = ~d;
  endtask
  // Read strobe, data taken one and a half cycles after the read edge
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(negedge clock);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clock);
    regRead = 1'b0;
    @(negedge clock);
    d = regRdData;
  endtask
endmodule
`default_nettype wire

//--- sim/power_monitor_monitor.sv
// Port checks on the power monitor result and limit registers.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module power_monitor_monitor
  import power_monitor_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regRdData,
  input wire logic sampleValid,
  input wire logic [1:0] busRangeSelect,
  input wire logic [1:0] shuntGainSelect,
  input wire logic alertPinOut,
  input wire logic alertPinOe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // A single read of one address
  sequence s_rd(a);
    regRead && regAddr == a ##1 !regRead;
  endsequence
  property p_pin_low; alertPinOut == 1'b0; endproperty
  a_pin_low: assert property (p_pin_low) else $error("alert output not low");
  property p_cal_b0; s_rd(ADDR_CAL) |=> regRdData[0] == 1'b0; endproperty
  a_cal_b0: assert property (p_cal_b0) else $error("calibration bit 0 set");
  property p_bus_gap; s_rd(ADDR_BUS) ##0 !busRangeSelect[1] |=> !regRdData[2] && (busRangeSelect[0] || !regRdData[15]);
  endproperty
  a_bus_gap: assert property (p_bus_gap) else $error("unused bus bits set");
  property p_sign; s_rd(ADDR_SHUNT) ##0 shuntGainSelect == 2'b00 |=> regRdData[15:12] == {4{regRdData[12]}};
  endproperty
  a_sign: assert property (p_sign) else $error("shunt sign copies differ");
  property p_stat_hi; s_rd(ADDR_STATUS) |=> regRdData[15:4] == 12'h000; endproperty
  a_stat_hi: assert property (p_stat_hi) else $error("status upper bits set");
  property p_stands; !regRead ##1 !regRead |=> $stable(regRdData); endproperty
  a_stands: assert property (p_stands) else $error("read data changed without read");
  property p_done_clr;
    (!$past(sampleValid) && !$past(sampleValid, 2) && !$past(sampleValid, 3)) ##0 s_rd(ADDR_POWER) ##2 s_rd(ADDR_BUS)
      |=> !regRdData[1];
  endproperty
  a_done_clr: assert property (p_done_clr) else $error("done flag kept after power read");
  property p_alert_off;
    regWrite && regAddr == ADDR_AUX && !regWrData[AUX_ALERT_EN] && !regWrData[AUX_FORCE]
      ##1 !(regWrite && regAddr == ADDR_AUX) [*2] |-> !alertPinOe;
  endproperty
  a_alert_off: assert property (p_alert_off) else $error("alert active while disabled");
endmodule
bind power_monitor_result_registers power_monitor_monitor i_power_monitor_monitor (.clock, .rst_b, .regAddr,
  .regWrData, .regWrite, .regRead, .regRdData, .sampleValid, .busRangeSelect, .shuntGainSelect, .alertPinOut,
  .alertPinOe);
`default_nettype wire

//--- sim/power_monitor_result_registers_tb.sv
// Self-checking bench for the result, calibration and limit registers.
// Assumes the host model for register access and a 40 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module power_monitor_result_registers_tb;
  import power_monitor_pkg::*;
  typedef struct {logic [15:0] s; logic [13:0] b; logic [15:0] c; logic [15:0] p; logic [3:0] w;} row_t;
  row_t rows [4] = '{'{16'h0100, 14'h0800, 16'h0100, 16'h0068, 4'h0}, '{16'h0400, 14'h1388, 16'h0400, 16'h0400, 4'h8},
    '{16'hFC00, 14'h0200, 16'hFC00, 16'h0068, 4'h5}, '{16'h0000, 14'h1FFF, 16'h0000, 16'h0000, 4'h2}};
  logic [19:0] rstTab [8] = '{20'h50000, 20'h67F80, 20'h7FF00, 20'h80000, 20'h40000, 20'hA0000, 20'h20000, 20'h10000};
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic sampleValid = 1'b0;
  logic [15:0] sampleShunt = 16'h0000;
  logic [13:0] sampleBus = 14'h0000;
  logic [1:0] busRangeSelect = 2'b01;
  logic [3:0] shuntConversionSetting = 4'h3;
  logic [1:0] shuntGainSelect = 2'b00;
  logic triggeredMode = 1'b1;
  logic [15:0] regRdData, regWrData, rdv;
  logic [3:0] regAddr;
  logic regWrite, regRead, alertPinOut, alertPinOe;
  int err_total = 0;
  int checked = 0;
  initial forever #12.5 clock = ~clock;
  power_monitor_result_registers i_power_monitor_result_registers (.clock, .rst_b, .regAddr, .regWrData, .regWrite,
    .regRead, .regRdData, .sampleValid, .sampleShunt, .sampleBus, .busRangeSelect, .shuntGainSelect,
    .shuntConversionSetting, .triggeredMode, .alertPinIn(1'b0), .alertPinOut, .alertPinOe);
  power_monitor_host i_power_monitor_host (.clock, .regRdData, .regAddr, .regWrData, .regWrite, .regRead);
  // Compare and count
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rc(input logic [3:0] a, input logic [15:0] e, input string n);
    i_power_monitor_host.rd(a, rdv);
    chk(n, e, rdv);
  endtask
  // One conversion pulse, then wait out the result and warning latency
  task automatic smp(input logic [15:0] s, input logic [13:0] b);
    @(negedge clock);
    sampleShunt = s;
    sampleBus = b;
    sampleValid = 1'b1;
    @(negedge clock);
    sampleValid = 1'b0;
    sampleShunt = ~s;
    sampleBus = ~b;
    repeat (4) @(negedge clock);
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Main sequence: table rows, then 60 V, alert, overflow and reset cases
  initial begin
    repeat (8) @(negedge clock);
    rst_b = 1'b1;
    i_power_monitor_host.wr(ADDR_CAL, 16'h1000);
    i_power_monitor_host.wr(ADDR_SHUNT_LIM, 16'h02FE);
    i_power_monitor_host.wr(ADDR_BUS_LIM, 16'h5010);
    foreach (rows[i]) begin
      smp(rows[i].s, rows[i].b);
      rc(ADDR_SHUNT, rows[i].s, "shunt");
      rc(ADDR_BUS, {rows[i].b[12:0], 3'b010}, "bus");
      rc(ADDR_CURRENT, rows[i].c, "current");
      rc(ADDR_POWER, rows[i].p, "power");
      rc(ADDR_BUS, {rows[i].b[12:0], 3'b000}, "done");
      rc(ADDR_STATUS, {12'h000, rows[i].w}, "warn");
      i_power_monitor_host.wr(ADDR_STATUS, 16'h000F);
      rc(ADDR_STATUS, 16'h0000, "clear");
    end
    busRangeSelect = 2'b10;
    i_power_monitor_host.wr(ADDR_AUX, 16'h0080);
    smp(16'h0400, 14'h1388);
    rc(ADDR_POWER, 16'h0200, "power60");
    rc(ADDR_BUS, {14'h1388, 2'b00}, "bus60");
    for (int k = 0; k < 8 && alertPinOe !== 1'b1; k++) @(negedge clock);
    chk("alert", 16'h0001, {15'h0000, alertPinOe});
    if (alertPinOe !== 1'b1) tally_and_finish();
    i_power_monitor_host.wr(ADDR_AUX, 16'h0000);
    shuntConversionSetting = 4'h0;
    i_power_monitor_host.wr(ADDR_CAL, 16'hFFFF);
    rc(ADDR_CAL, 16'hFFFE, "cal");
    smp(16'h07FF, 14'h0100);
    i_power_monitor_host.rd(ADDR_BUS, rdv);
    chk("ovf", 16'h0001, {15'h0000, rdv[0]});
    // Forced alert pulls the open-drain pin low without any enable
    i_power_monitor_host.wr(ADDR_AUX, 16'h0100);
    repeat (2) @(negedge clock);
    chk("force", 16'h0001, {15'h0000, alertPinOe});
    chk("pinlevel", 16'h0000, {15'h0000, alertPinOut});
    i_power_monitor_host.wr(ADDR_AUX, 16'h0000);
    // Free-running mode leaves the done flag low; sign copies follow the gain
    triggeredMode = 1'b0;
    shuntGainSelect = 2'b01;
    i_power_monitor_host.rd(ADDR_POWER, rdv);
    smp(16'h1000, 14'h0100);
    rc(ADDR_SHUNT, 16'hF000, "gain");
    i_power_monitor_host.rd(ADDR_BUS, rdv);
    chk("freedone", 16'h0000, {15'h0000, rdv[1]});
    // A configuration write clears a raised done flag
    triggeredMode = 1'b1;
    shuntGainSelect = 2'b00;
    smp(16'h0100, 14'h0100);
    i_power_monitor_host.wr(ADDR_CONFIG, 16'h0000);
    i_power_monitor_host.rd(ADDR_BUS, rdv);
    chk("cfgclear", 16'h0000, {15'h0000, rdv[1]});
    busRangeSelect = 2'b00;
    rst_b = 1'b0;
    @(negedge clock);
    rst_b = 1'b1;
    i_power_monitor_host.wr(ADDR_CURRENT, 16'h1234);
    foreach (rstTab[i]) rc(rstTab[i][19:16], rstTab[i][15:0], "reset");
    tally_and_finish();
  end
endmodule
`default_nettype wire
